/* File: hspw_core.sv */
`timescale 1ns/1ps
`default_nettype none
module hspw_core #(
    parameter int NCH = hspw_pkg::NCH_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Prescaled timer clock enable
    input wire logic tmr_tick,
    // APB slave
    input wire hspw_pkg::hspw_apb_req_t apb_req,
    output var hspw_pkg::hspw_apb_rsp_t apb_rsp,
    // Compare pins
    output var logic [NCH-1:0] pin_true_out,
    output var logic [NCH-1:0] pin_true_oe,
    output var logic [NCH-1:0] pin_inv_out,
    output var logic [NCH-1:0] pin_inv_oe,
    // Status
    output var logic overflow_flag
);
    import hspw_pkg::*;

    if (NCH < 1 || NCH > NCH_MAX) begin : g_nch_check
        $error("NCH must lie between 1 and 4.");
    end

    typedef logic [CNT_W-1:0] hspw_cnt_t;

    function automatic logic addr_ok(input logic [31:0] a);
        logic [5:0] idx;
        idx = a[7:2];
        addr_ok = (a[31:8] == 24'h000000) && (a[1:0] == 2'h0)
            && (int'(idx) < 4 + NCH);
    endfunction : addr_ok

    // Register group state.
    logic slope_select;
    logic update_lock;
    logic [NCH-1:0] pwm_enable_channel;
    hspw_cnt_t top_buf;
    hspw_cnt_t cmp_buf [NCH];
    hspw_mode_t mode_wr [NCH];
    logic [NCH-1:0] port_t, port_i, dir_t, dir_i;
    logic next_slope, next_lock;
    logic [NCH-1:0] next_pwm_en;
    hspw_cnt_t next_top_buf;
    hspw_cnt_t next_cmp_buf [NCH];
    hspw_mode_t next_mode_wr [NCH];
    logic [NCH-1:0] next_port_t, next_port_i, next_dir_t, next_dir_i;
    logic next_ovf;
    hspw_apb_rsp_t next_rsp;
    logic setup, access, wr;

    // Timer group state.
    hspw_cnt_t counter_value, next_cnt;
    hspw_dir_t cnt_dir, next_dir;
    hspw_cnt_t top_compare_value, next_top;
    hspw_cnt_t channel_compare_value [NCH];
    hspw_cnt_t next_cmp [NCH];
    hspw_mode_t output_mode_code [NCH];
    hspw_mode_t next_act [NCH];
    logic [NCH-1:0] wave_n, next_wave_n, match, waveform_output;
    logic [NCH-1:0] next_pin_t, next_pin_i;
    logic run, wrap, cyc_end, load, ovf_hit;
    hspw_cnt_t top_eff;

    assign setup = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign wr = access && apb_req.pwrite && addr_ok(apb_req.paddr);

    always_comb begin
        next_slope = slope_select;
        next_lock = update_lock;
        next_pwm_en = pwm_enable_channel;
        next_top_buf = top_buf;
        next_cmp_buf = cmp_buf;
        next_mode_wr = mode_wr;
        next_port_t = port_t;
        next_port_i = port_i;
        next_dir_t = dir_t;
        next_dir_i = dir_i;
        next_rsp = '0;
        // The answer is built in the setup phase, so read data leaves a flop with no wait state.
        if (setup) begin
            next_rsp.pready = 1'b1;
            next_rsp.pslverr = !addr_ok(apb_req.paddr);
            case (apb_req.paddr[7:0])
                OFF_CTRL: begin
                    next_rsp.prdata[CTRL_SLOPE] = slope_select;
                    next_rsp.prdata[CTRL_LOCK] = update_lock;
                    next_rsp.prdata[CTRL_EN +: NCH] = pwm_enable_channel;
                end
                OFF_TOP: next_rsp.prdata[CNT_W-1:0] = top_buf;
                OFF_STAT: begin
                    next_rsp.prdata[STAT_OVF] = overflow_flag;
                    next_rsp.prdata[STAT_CNT +: CNT_W] = counter_value;
                end
                OFF_PORT: begin
                    next_rsp.prdata[PORT_VAL_T +: NCH] = port_t;
                    next_rsp.prdata[PORT_VAL_I +: NCH] = port_i;
                    next_rsp.prdata[PORT_DIR_T +: NCH] = dir_t;
                    next_rsp.prdata[PORT_DIR_I +: NCH] = dir_i;
                end
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (apb_req.paddr[7:0] == OFF_CHAN + 8'(4 * i)) begin
                            next_rsp.prdata[CHAN_CMP +: CNT_W] = cmp_buf[i];
                            next_rsp.prdata[CHAN_MODE +: 2] = mode_wr[i];
                            next_rsp.prdata[CHAN_ACT +: 2] = output_mode_code[i];
                        end
                    end
                end
            endcase
        end
        if (wr) begin
            case (apb_req.paddr[7:0])
                OFF_CTRL: begin
                    next_slope = apb_req.pwdata[CTRL_SLOPE];
                    next_lock = apb_req.pwdata[CTRL_LOCK];
                    next_pwm_en = apb_req.pwdata[CTRL_EN +: NCH];
                end
                OFF_TOP: next_top_buf = apb_req.pwdata[CNT_W-1:0];
                OFF_PORT: begin
                    next_port_t = apb_req.pwdata[PORT_VAL_T +: NCH];
                    next_port_i = apb_req.pwdata[PORT_VAL_I +: NCH];
                    next_dir_t = apb_req.pwdata[PORT_DIR_T +: NCH];
                    next_dir_i = apb_req.pwdata[PORT_DIR_I +: NCH];
                end
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (apb_req.paddr[7:0] == OFF_CHAN + 8'(4 * i)) begin
                            next_cmp_buf[i] = apb_req.pwdata[CHAN_CMP +: CNT_W];
                            next_mode_wr[i] = hspw_mode_t'(apb_req.pwdata[CHAN_MODE +: 2]);
                        end
                    end
                end
            endcase
        end
        // A hit in the clearing cycle keeps the flag set.
        next_ovf = ovf_hit || (overflow_flag && !(wr
            && apb_req.paddr[7:0] == OFF_STAT && apb_req.pwdata[STAT_OVF]));
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            slope_select <= 1'b0;
            update_lock <= 1'b0;
            pwm_enable_channel <= '0;
            top_buf <= TOP_RST;
            for (int i = 0; i < NCH; i++) begin
                cmp_buf[i] <= CMP_RST;
                mode_wr[i] <= OM_OFF;
            end
            port_t <= '0;
            port_i <= '0;
            dir_t <= '0;
            dir_i <= '0;
            overflow_flag <= 1'b0;
            apb_rsp <= '0;
        end else begin
            slope_select <= next_slope;
            update_lock <= next_lock;
            pwm_enable_channel <= next_pwm_en;
            top_buf <= next_top_buf;
            cmp_buf <= next_cmp_buf;
            mode_wr <= next_mode_wr;
            port_t <= next_port_t;
            port_i <= next_port_i;
            dir_t <= next_dir_t;
            dir_i <= next_dir_i;
            overflow_flag <= next_ovf;
            apb_rsp <= next_rsp;
        end
    end

    always_comb begin
        run = |pwm_enable_channel;
        // Top zero in single slope runs the full range to make the spike.
        top_eff = (!slope_select && top_compare_value == '0) ? CNT_MAX
            : top_compare_value;
        next_cnt = counter_value;
        next_dir = cnt_dir;
        if (!run) begin
            next_cnt = '0;
            next_dir = DIR_UP;
        end else if (tmr_tick) begin
            if (!slope_select) begin
                next_cnt = (counter_value >= top_eff) ? '0
                    : counter_value + 1'b1;
            end else begin
                case (cnt_dir)
                    DIR_UP: begin
                        if (counter_value >= top_compare_value) begin
                            next_cnt = (top_compare_value == '0) ? '0
                                : top_compare_value - 1'b1;
                            next_dir = DIR_DOWN;
                        end else begin
                            next_cnt = counter_value + 1'b1;
                        end
                    end
                    DIR_DOWN: begin
                        if (counter_value == '0) begin
                            next_cnt = (top_compare_value == '0) ? '0 : 10'h001;
                            next_dir = DIR_UP;
                        end else begin
                            next_cnt = counter_value - 1'b1;
                        end
                    end
                    default: next_dir = DIR_UP;
                endcase
            end
        end
        wrap = run && tmr_tick && !slope_select && counter_value >= top_eff;
        cyc_end = wrap || (run && tmr_tick && slope_select
            && cnt_dir == DIR_DOWN && counter_value == '0);
        ovf_hit = run && tmr_tick && (slope_select
            ? (next_dir == DIR_DOWN && next_cnt == '0 && counter_value != '0)
            : (next_cnt == top_eff && counter_value != top_eff));
        // The top and compare buffers move in as one set so a cycle never mixes old and new.
        load = (!run || cyc_end) && !update_lock;
        next_top = load ? top_buf : top_compare_value;
        for (int i = 0; i < NCH; i++) begin
            next_cmp[i] = load ? cmp_buf[i] : channel_compare_value[i];
            match[i] = run && tmr_tick && pwm_enable_channel[i]
                && counter_value == channel_compare_value[i];
            next_act[i] = (match[i] || !run) ? mode_wr[i]
                : output_mode_code[i];
            next_wave_n[i] = wave_n[i];
            if (run && tmr_tick && pwm_enable_channel[i]) begin
                if (!slope_select) begin
                    if (top_compare_value == '0) begin
                        next_wave_n[i] = wrap;
                    end else if (top_compare_value == CNT_MAX) begin
                        next_wave_n[i] = 1'b1;
                    end else if (wrap) begin
                        next_wave_n[i] = 1'b1;
                    end else if (match[i]) begin
                        next_wave_n[i] = 1'b0;
                    end
                end else if (top_compare_value == '0) begin
                    next_wave_n[i] = 1'b0;
                end else if (top_compare_value == CNT_MAX) begin
                    next_wave_n[i] = 1'b1;
                end else if (output_mode_code[i] == OM_COMP) begin
                    if (cyc_end) begin
                        next_wave_n[i] = 1'b1;
                    end else if (match[i]) begin
                        next_wave_n[i] = 1'b0;
                    end
                end else if (match[i]) begin
                    next_wave_n[i] = (cnt_dir == DIR_DOWN);
                end
            end
            // Inverting mode is the non-inverted wave turned over.
            waveform_output[i] = wave_n[i]
                ^ (output_mode_code[i] == OM_INV);
            next_pin_t[i] = (output_mode_code[i] != OM_OFF && dir_t[i])
                ? waveform_output[i] : port_t[i];
            next_pin_i[i] = (output_mode_code[i] == OM_COMP && dir_i[i])
                ? !waveform_output[i] : port_i[i];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            counter_value <= '0;
            cnt_dir <= DIR_UP;
            top_compare_value <= TOP_RST;
            for (int i = 0; i < NCH; i++) begin
                channel_compare_value[i] <= CMP_RST;
                output_mode_code[i] <= OM_OFF;
            end
            wave_n <= '0;
            pin_true_out <= '0;
            pin_inv_out <= '0;
            pin_true_oe <= '0;
            pin_inv_oe <= '0;
        end else begin
            counter_value <= next_cnt;
            cnt_dir <= next_dir;
            top_compare_value <= next_top;
            channel_compare_value <= next_cmp;
            output_mode_code <= next_act;
            wave_n <= next_wave_n;
            pin_true_out <= next_pin_t;
            pin_inv_out <= next_pin_i;
            pin_true_oe <= dir_t;
            pin_inv_oe <= dir_i;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_ss_at_top;
        run && tmr_tick && !slope_select && counter_value == top_eff;
    endsequence
    sequence s_ds_peak;
        run && tmr_tick && slope_select && cnt_dir == DIR_UP
            && counter_value == top_compare_value && top_compare_value != '0;
    endsequence

    AST_SS_WRAP: assert property (s_ss_at_top |=> counter_value == '0)
        else $error("Single-slope counter did not clear after top.");
    AST_SS_STEP: assert property (run && tmr_tick && !slope_select
        && counter_value < top_eff |=> counter_value == $past(counter_value) + 1'b1)
        else $error("Single-slope counter did not step by one.");
    AST_HOLD: assert property (run && !tmr_tick |=> $stable(counter_value))
        else $error("Counter moved without a timer tick.");
    AST_SS_OVF: assert property (run && tmr_tick && !slope_select
        && counter_value == top_eff - 1'b1 |=> overflow_flag)
        else $error("Overflow flag missing at top.");
    AST_DS_PEAK: assert property (s_ds_peak |=> cnt_dir == DIR_DOWN
        && counter_value == $past(top_compare_value) - 1'b1)
        else $error("Dual-slope counter did not turn at top.");
    AST_DS_OVF: assert property (run && tmr_tick && slope_select
        && cnt_dir == DIR_DOWN && counter_value == 10'h001 |=> overflow_flag)
        else $error("Overflow flag missing at bottom.");
    AST_DS_UP_MATCH: assert property (match[0] && slope_select && cnt_dir == DIR_UP
        && top_compare_value != '0 && top_compare_value != CNT_MAX
        && output_mode_code[0] != OM_COMP |=> !wave_n[0])
        else $error("Dual-slope up-count match did not clear the wave.");
    AST_SS_NONINV: assert property (s_ss_at_top ##0 (top_compare_value != CNT_MAX
        && top_compare_value != '0 && pwm_enable_channel[0])
        |=> wave_n[0] ##1 (pin_true_out[0] || !($past(dir_t[0])
        && $past(output_mode_code[0]) == OM_NONINV)))
        else $error("Waveform not set at bottom.");
    AST_PIN_OFF: assert property (output_mode_code[0] == OM_OFF
        |=> pin_true_out[0] == $past(port_t[0]) && pin_inv_out[0] == $past(port_i[0]))
        else $error("Disconnected pin does not show the port value.");
    AST_PIN_COMP: assert property (output_mode_code[0] == OM_COMP && dir_t[0]
        && dir_i[0]
        |=> pin_inv_out[0] != pin_true_out[0])
        else $error("Complementary pins are not opposite.");
    AST_MODE: assert property (!$stable(output_mode_code[0])
        |-> $past(match[0]) || $past(!run))
        else $error("Mode code changed away from a compare match.");
    AST_LOCK: assert property (update_lock && run
        |=> channel_compare_value[0] == $past(channel_compare_value[0]))
        else $error("Compare value loaded while locked.");

endmodule : hspw_core
`default_nettype wire

/* File: hspw_pkg.sv */
package hspw_pkg;

    // Counter geometry.
    localparam int CNT_W = 10;
    localparam int NCH_DEF = 3;
    localparam int NCH_MAX = 4;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TOP = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_PORT = 8'h0c;
    localparam logic [7:0] OFF_CHAN = 8'h10;

    // Field positions.
    localparam int CTRL_SLOPE = 0;
    localparam int CTRL_LOCK = 1;
    localparam int CTRL_EN = 2;
    localparam int STAT_OVF = 0;
    localparam int STAT_CNT = 16;
    localparam int PORT_VAL_T = 0;
    localparam int PORT_VAL_I = 8;
    localparam int PORT_DIR_T = 16;
    localparam int PORT_DIR_I = 24;
    localparam int CHAN_CMP = 0;
    localparam int CHAN_MODE = 12;
    localparam int CHAN_ACT = 16;

    // Reset values and counter maximum.
    localparam logic [CNT_W-1:0] TOP_RST = 10'h3ff;
    localparam logic [CNT_W-1:0] CMP_RST = 10'h000;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;

    typedef enum logic [1:0] {
        OM_OFF = 2'h0,
        OM_COMP = 2'h1,
        OM_NONINV = 2'h2,
        OM_INV = 2'h3
    } hspw_mode_t;

    typedef enum {DIR_UP, DIR_DOWN} hspw_dir_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } hspw_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } hspw_apb_rsp_t;

endpackage : hspw_pkg

/* File: hspw_stage.sv */
`timescale 1ns/1ps
`default_nettype none
// Half-bridge gate inputs behind the compare pins; a released pin is pulled down.
module hspw_stage #(
    parameter int NCH = 3
) (
    // Clock
    input wire logic core_clk,
    // Compare pins
    input wire logic [NCH-1:0] pin_true_out,
    input wire logic [NCH-1:0] pin_true_oe,
    input wire logic [NCH-1:0] pin_inv_out,
    input wire logic [NCH-1:0] pin_inv_oe,
    // Resolved wire levels
    output wire logic [NCH-1:0] wire_t,
    output wire logic [NCH-1:0] wire_i,
    output var int shoot
);
    assign wire_t = pin_true_oe & pin_true_out;
    assign wire_i = pin_inv_oe & pin_inv_out;
    initial shoot = 0;
    // Both legs on together would short the supply, so every such cycle is counted.
    always @(posedge core_clk) begin
        if ((wire_t & wire_i) != '0) begin
            shoot <= shoot + 1;
        end
    end
endmodule : hspw_stage
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hspw_pkg::*;
    typedef struct packed {
        logic err;
        logic [31:0] mask;
        logic [31:0] data;
    } hspw_exp_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic tmr_tick = 1'b1;
    logic tick_half = 1'b0;
    hspw_apb_req_t apb_req = '0;
    hspw_apb_rsp_t apb_rsp;
    logic [2:0] pin_true_out, pin_true_oe, pin_inv_out, pin_inv_oe, wire_t, wire_i;
    logic overflow_flag;
    logic [31:0] meas_res;
    logic [31:0] cmp;
    int shoot;
    int bad_count = 0;
    int check_count = 0;
    int seed = 11;
    hspw_exp_t exp_q[$];
    event meas_ev;

    hspw_core #(.NCH(3)) DUT (.core_clk(core_clk), .reset(reset), .tmr_tick(tmr_tick),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_true_out(pin_true_out),
        .pin_true_oe(pin_true_oe), .pin_inv_out(pin_inv_out), .pin_inv_oe(pin_inv_oe),
        .overflow_flag(overflow_flag));
    hspw_stage #(.NCH(3)) stage (.core_clk(core_clk), .pin_true_out(pin_true_out),
        .pin_true_oe(pin_true_oe), .pin_inv_out(pin_inv_out), .pin_inv_oe(pin_inv_oe),
        .wire_t(wire_t), .wire_i(wire_i), .shoot(shoot));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    // Halving the tick rate must double every period without changing the duty.
    always @(posedge core_clk) begin
        tmr_tick <= tick_half ? ~tmr_tick : 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
        check_count++;
        if (seen !== exp_v) begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp_v);
        end
    endtask : check

    always @(posedge core_clk) begin
        if (apb_req.penable && apb_rsp.pready === 1'b1) begin
            check({31'h0, apb_rsp.pslverr}, {31'h0, exp_q[0].err});
            check(apb_rsp.prdata & exp_q[0].mask, exp_q[0].data);
            void'(exp_q.pop_front());
        end
    end

    always @(meas_ev) begin
        check(meas_res, exp_q[0].data);
        void'(exp_q.pop_front());
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] mask, input logic [31:0] exp_v, input logic err);
        int n;
        n = 0;
        exp_q.push_back('{err, mask, exp_v});
        @(posedge core_clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= w;
        apb_req.paddr <= {24'h0, a};
        apb_req.pwdata <= d;
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
        end
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
            input logic err);
        apb(1'b0, a, 32'h0, m, e, err);
    endtask : rd

    // Stopping the counter first makes the new mode and compare apply at once.
    task automatic cfg(input logic [31:0] ctrl, input logic [31:0] top,
            input logic [31:0] chan, input logic [31:0] port);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_PORT, port);
        wr(OFF_TOP, top);
        wr(OFF_CHAN, chan);
        wr(OFF_CTRL, ctrl);
        repeat (20) @(posedge core_clk);
    endtask : cfg

    // 48 cycles span whole periods of 4, 6 and 8 cycles, so the phase does not matter.
    task automatic measure(input logic inv, input logic [31:0] exp_v);
        int hi;
        hi = 0;
        exp_q.push_back('{1'b0, 32'hffffffff, exp_v});
        repeat (48) begin
            @(negedge core_clk);
            hi += int'(inv ? wire_i[0] : wire_t[0]);
        end
        meas_res = 32'(hi);
        -> meas_ev;
    endtask : measure

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        print_verdict;
    end

    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        rd(OFF_TOP, 32'h3ff, 32'h3ff, 1'b0);
        rd(OFF_CHAN, 32'hffffffff, 32'h0, 1'b0);
        rd(OFF_STAT, 32'hffffffff, 32'h0, 1'b0);
        rd(8'h40, 32'hffffffff, 32'h0, 1'b1);
        // The wave is high from the bottom through the compare count: (cmp + 1) of 4.
        cfg(32'h4, 32'h3, 32'h2001, 32'h01010001);
        measure(1'b0, 32'h18);
        measure(1'b1, 32'h0);
        rd(OFF_CHAN, 32'h3ffff, 32'h22001, 1'b0);
        rd(OFF_STAT, 32'h1, 32'h1, 1'b0);
        cfg(32'h4, 32'h3, 32'h3000, 32'h01010001);
        measure(1'b0, 32'h24);
        cfg(32'h4, 32'h3, 32'h1002, 32'h01010001);
        measure(1'b0, 32'h24);
        measure(1'b1, 32'hc);
        cmp = 32'h1 + ($unsigned($random(seed)) % 32'h3);
        cfg(32'h4, 32'h3, 32'h2000 | cmp, 32'h01010001);
        measure(1'b0, (cmp + 32'h1) * 32'hc);
        wr(OFF_CTRL, 32'h6);
        wr(OFF_CHAN, 32'h2000 | (cmp ^ 32'h3));
        repeat (20) @(posedge core_clk);
        measure(1'b0, (cmp + 32'h1) * 32'hc);
        wr(OFF_CTRL, 32'h4);
        repeat (20) @(posedge core_clk);
        measure(1'b0, ((cmp ^ 32'h3) + 32'h1) * 32'hc);
        tick_half <= 1'b1;
        cfg(32'h4, 32'h3, 32'h2001, 32'h01010001);
        measure(1'b0, 32'h18);
        tick_half <= 1'b0;
        cfg(32'h5, 32'h3, 32'h2001, 32'h01010001);
        measure(1'b0, 32'h10);
        cfg(32'h5, 32'h3, 32'h3001, 32'h01010001);
        measure(1'b0, 32'h20);
        cfg(32'h5, 32'h3, 32'h1001, 32'h01010001);
        measure(1'b0, 32'h8);
        cfg(32'h5, 32'h0, 32'h2001, 32'h01010001);
        measure(1'b0, 32'h0);
        cfg(32'h5, 32'h0, 32'h3001, 32'h01010001);
        measure(1'b0, 32'h30);
        cfg(32'h4, 32'h3ff, 32'h2001, 32'h01010001);
        measure(1'b0, 32'h30);
        cfg(32'h4, 32'h3, 32'h3001, 32'h00000001);
        measure(1'b0, 32'h0);
        cfg(32'h4, 32'h3, 32'h0001, 32'h00010001);
        measure(1'b0, 32'h30);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_STAT, 32'h1);
        rd(OFF_STAT, 32'h1, 32'h0, 1'b0);
        check(32'(shoot), 32'h0);
        print_verdict;
    end
endmodule : tb
`default_nettype wire
